/* File: sfsfe_pkg.sv */
// Constants and types for the serial flash SPI front end
package sfsfe_pkg;

  // ****************
  // Instruction codes
  // ****************
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT = 8'h01;
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FAST_RD = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'h20;
  localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLK64_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  // ****************
  // Status byte layout
  // ****************
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_FROM_BOTTOM = 5;
  localparam int ST_LOCK = 7;
  localparam logic [8:0] VIEW_RESET = 9'h000;

  // ****************
  // Frame framing, in clock groups of eight
  // ****************
  localparam logic [2:0] LEAD_STAT = 3'h1;
  localparam logic [2:0] LEAD_RD = 3'h4;
  localparam logic [2:0] LEAD_FAST = 3'h5;
  localparam logic [2:0] LEAD_DIO = 3'h3;
  localparam logic [2:0] MIN_WR_STAT = 3'h2;
  localparam logic [2:0] MIN_ADDR = 3'h4;
  localparam logic [2:0] MIN_CMD = 3'h1;
  // Array contents are outside this block; reads return erased data
  localparam logic [7:0] FLASH_BLANK = 8'hFF;

  // ****************
  // Timing
  // ****************
  localparam int MCLK_MHZ = 100;
  localparam int WR_INHIBIT_US = 10;
  localparam int WR_INHIBIT_CYC = WR_INHIBIT_US * MCLK_MHZ;
  localparam int BUSY_US = 1;
  localparam int BUSY_CYC = BUSY_US * MCLK_MHZ;
  localparam int CNT_W = 20;

  // Operating mode of the core
  typedef enum logic [1:0] {MD_READY, MD_BUSY, MD_SLEEP} sfsfe_mode_t;

endpackage

/* File: sfsfe_top.sv */
// Serial flash SPI front end: select, pause, dual lines, status and write guards
// ****************
// Summary of operation
// - Select high deselects and floats outputs
// - No instruction before first select falling edge
// - Sample input rising edge, drive falling
// - SPI modes 0 and 3 both work
// - Dual reads drive both lines; only line 0 also takes input
// - Pause floats outputs, ignores input and clock
// - Pause starts at pin or falling clock
// - Pause ends at pin or falling clock
// - Pause keeps partial instruction state intact
// - Low supply holds all in reset but the guard, bottom-select and lock bits
// - Writes refused until inhibit delay elapses
// - Write latch needed before any write
// - Write latch clears after write finishes
// - Write latch is status bit one
// - Busy bit zero; only status read allowed
// - Sleep ignores all but wake instruction
// - Guard bits three and two, default zero
// - Bottom-select bit picks guarded array end
// - Lock and low protect refuse guard writes
// - Status bits six and four read zero
// - Lock bit with protect low blocks status writes only
// - Writes touching guarded area are ignored
// - Opcode first, MSB first, select bounds frame
// - Writes need select rising on byte boundary
// ****************
`timescale 1ns/10ps

module sfsfe_top #(
  parameter int unsigned INHIBIT_CYC = sfsfe_pkg::WR_INHIBIT_CYC,
  parameter int unsigned BUSY_CYC = sfsfe_pkg::BUSY_CYC
) (
  // System clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Supply monitor, high above the write threshold
  input wire logic supply_ok,
  // Serial bus control from the master
  input wire logic serial_clk,
  input wire logic sel_b,
  input wire logic hold_b,
  input wire logic protect_b,
  // Data line 0, the serial input in single-line mode
  input wire logic dual_line_0_in,
  output logic dual_line_0_out,
  output logic dual_line_0_oe,
  // Data line 1, the serial output in single-line mode
  input wire logic dual_line_1_in,
  output logic dual_line_1_out,
  output logic dual_line_1_oe
);
  import sfsfe_pkg::*;

  // ****************
  // Link side, timed by the serial clock
  // ****************
  logic frame_clr;
  logic pause;
  logic hold_lat_reg;
  logic [2:0] bit_idx_reg;
  logic [2:0] byte_cnt_reg;
  logic [2:0] byte_next;
  logic [7:0] shift_reg;
  logic [7:0] frame_op_reg;
  logic [7:0] frame_arg_reg;
  logic [2:0] frame_len_reg;
  logic frame_whole_reg;
  logic frame_top_reg;
  logic frame_tog_reg;
  logic [8:0] view_s1_reg;
  logic [8:0] view_s2_reg;
  logic out0_reg;
  logic out1_reg;
  logic oe0_reg;
  logic oe1_reg;
  logic link_sleep;
  logic link_busy;

  // Frame logic clears whenever deselected or unpowered
  assign frame_clr = sel_b | ~supply_ok;

  // Pause follows the pin while the clock is low, else the last latch
  assign pause = serial_clk ? hold_lat_reg : ~hold_b;
  assign byte_next = (byte_cnt_reg == 3'h7) ? 3'h7 : byte_cnt_reg + 3'h1;
  assign link_sleep = view_s2_reg[8];
  assign link_busy = view_s2_reg[ST_BUSY];

  // Pause level frozen at each rising edge for the high phase, so a pin
  // change while the clock is high only takes effect at the next fall
  always_ff @(posedge serial_clk or posedge frame_clr) begin
    if (frame_clr) begin
      hold_lat_reg <= 1'b0;
    end else begin
      hold_lat_reg <= ~hold_b;
    end
  end

  // Bit and byte counters; a paused edge changes nothing
  always_ff @(posedge serial_clk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_idx_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else if (hold_b) begin
      bit_idx_reg <= bit_idx_reg + 3'h1;
      shift_reg <= {shift_reg[6:0], dual_line_0_in};
      if (bit_idx_reg == 3'h7) begin
        byte_cnt_reg <= byte_next;
      end
    end
  end

  // Frame summary; survives deselect so the system side can act on it
  always_ff @(posedge serial_clk or negedge supply_ok) begin
    if (!supply_ok) begin
      frame_op_reg <= 8'h00;
      frame_arg_reg <= 8'h00;
      frame_len_reg <= 3'h0;
      frame_whole_reg <= 1'b0;
      frame_top_reg <= 1'b0;
      frame_tog_reg <= 1'b0;
    end else if (!sel_b && hold_b) begin
      frame_whole_reg <= (bit_idx_reg == 3'h7);
      if (bit_idx_reg == 3'h7) begin
        frame_len_reg <= byte_next;
        if (byte_cnt_reg == 3'h0) begin
          frame_op_reg <= {shift_reg[6:0], dual_line_0_in};
          frame_tog_reg <= ~frame_tog_reg;
        end
        if (byte_cnt_reg == 3'h1) begin
          frame_arg_reg <= {shift_reg[6:0], dual_line_0_in};
          frame_top_reg <= dual_line_0_in;
        end
      end
    end
  end

  // Status view into the link domain; read long after frame start
  always_ff @(posedge serial_clk or negedge supply_ok) begin
    if (!supply_ok) begin
      view_s1_reg <= VIEW_RESET;
      view_s2_reg <= VIEW_RESET;
    end else begin
      view_s1_reg <= view_reg;
      view_s2_reg <= view_s1_reg;
    end
  end

  // Output drive on falling edges; idle level of the clock is irrelevant
  always_ff @(negedge serial_clk or posedge frame_clr) begin
    if (frame_clr) begin
      out0_reg <= 1'b0;
      out1_reg <= 1'b0;
      oe0_reg <= 1'b0;
      oe1_reg <= 1'b0;
    end else if (hold_b) begin
      oe0_reg <= 1'b0;
      oe1_reg <= 1'b0;
      out0_reg <= 1'b0;
      out1_reg <= 1'b0;
      if (frame_op_reg == OP_RD_STAT && byte_cnt_reg >= LEAD_STAT && !link_sleep) begin
        oe1_reg <= 1'b1;
        out1_reg <= view_s2_reg[bit_idx_reg ^ 3'h7];
      end else if (!link_sleep && !link_busy) begin
        if ((frame_op_reg == OP_RD && byte_cnt_reg >= LEAD_RD) ||
            (frame_op_reg == OP_FAST_RD && byte_cnt_reg >= LEAD_FAST)) begin
          oe1_reg <= 1'b1;
          out1_reg <= FLASH_BLANK[bit_idx_reg ^ 3'h7];
        end else if ((frame_op_reg == OP_DUAL_OUT && byte_cnt_reg >= LEAD_FAST) ||
            (frame_op_reg == OP_DUAL_IO && byte_cnt_reg >= LEAD_DIO)) begin
          oe0_reg <= 1'b1;
          oe1_reg <= 1'b1;
          out1_reg <= FLASH_BLANK[{bit_idx_reg[1:0], 1'b0} ^ 3'h7];
          out0_reg <= FLASH_BLANK[{bit_idx_reg[1:0], 1'b1} ^ 3'h7];
        end
      end
    end
  end

  // Enables drop at once on pause; select high clears the flops
  assign dual_line_0_oe = oe0_reg & ~pause;
  assign dual_line_1_oe = oe1_reg & ~pause;
  assign dual_line_0_out = out0_reg;
  assign dual_line_1_out = out1_reg;

  // ****************
  // System side, timed by mclk
  // ****************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic sel_prev_reg;
  logic sys_rst;
  logic sel_rise;
  logic armed_reg;
  logic tog_seen_reg;
  logic go;
  logic may_write;
  logic guarded;
  logic wr_stat_ok;
  logic prog_ok;
  logic [CNT_W-1:0] inhibit_reg;
  logic [CNT_W-1:0] busy_cnt_reg;
  sfsfe_mode_t mode_reg;
  logic latch_reg;
  logic [1:0] guard_reg;
  logic bottom_reg;
  logic lock_reg;
  logic [8:0] view_reg;

  // Erase or program aimed at an address inside the array
  function automatic logic is_sized_write(input logic [7:0] op);
    is_sized_write = (op == OP_PAGE_PROG) || (op == OP_SECT_ERASE) ||
      (op == OP_BLK32_ERASE) || (op == OP_BLK64_ERASE);
  endfunction

  // Two-flop synchronisers for supply, select and protect
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sel_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {supply_ok, sel_b, protect_b};
      sync2_reg <= sync1_reg;
      sel_prev_reg <= sync2_reg[1];
    end
  end

  assign sys_rst = !rst_b || !sync2_reg[2];
  assign sel_rise = sync2_reg[1] && !sel_prev_reg;

  // Armed only once select has been seen falling after reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else if (sel_prev_reg && !sync2_reg[1]) begin
      armed_reg <= 1'b1;
    end
  end

  // Frame summary is held still while select is high, so reading it
  // after the synchronised select edge is safe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tog_seen_reg <= frame_tog_reg;
    end else if (sel_rise) begin
      tog_seen_reg <= frame_tog_reg;
    end
  end

  assign go = sel_rise && armed_reg && (frame_tog_reg != tog_seen_reg);
  assign may_write = latch_reg && (inhibit_reg == '0) && frame_whole_reg;
  assign guarded = guard_reg[1] || (guard_reg[0] && (frame_top_reg != bottom_reg));

  // Status write accepted: latch set, boundary, not locked by the pin
  assign wr_stat_ok = go && (mode_reg == MD_READY) && (frame_op_reg == OP_WR_STAT) &&
    (frame_len_reg >= MIN_WR_STAT) && may_write && !(lock_reg && !sync2_reg[0]);

  // Program or erase accepted only clear of the guarded region
  assign prog_ok = go && (mode_reg == MD_READY) && may_write &&
    ((is_sized_write(frame_op_reg) && (frame_len_reg >= MIN_ADDR) && !guarded) ||
     (((frame_op_reg == OP_CHIP_ERASE) || (frame_op_reg == OP_CHIP_ERASE_ALT)) &&
      (frame_len_reg >= MIN_CMD) && (guard_reg == 2'b00)));

  // Power-up write inhibit countdown
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      inhibit_reg <= CNT_W'(INHIBIT_CYC);
    end else if (inhibit_reg != '0) begin
      inhibit_reg <= inhibit_reg - 1'b1;
    end
  end

  // Mode, write latch and busy timer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_reg <= MD_READY;
      latch_reg <= 1'b0;
      busy_cnt_reg <= '0;
    end else begin
      case (mode_reg)
        MD_READY: begin
          if (go && frame_whole_reg) begin
            case (frame_op_reg)
              OP_WR_EN: begin
                if (inhibit_reg == '0) begin
                  latch_reg <= 1'b1;
                end
              end
              OP_WR_DIS: latch_reg <= 1'b0;
              OP_SLEEP: mode_reg <= MD_SLEEP;
              default: ;
            endcase
          end
          if (wr_stat_ok || prog_ok) begin
            mode_reg <= MD_BUSY;
            busy_cnt_reg <= CNT_W'(BUSY_CYC);
          end
        end
        MD_BUSY: begin
          // Every frame but a status read is dropped here
          if (busy_cnt_reg <= CNT_W'(1)) begin
            mode_reg <= MD_READY;
            latch_reg <= 1'b0;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
          end
        end
        MD_SLEEP: begin
          if (go && frame_op_reg == OP_WAKE) begin
            mode_reg <= MD_READY;
          end
        end
        default: mode_reg <= MD_READY;
      endcase
    end
  end

  // Non-volatile bits: kept through a supply dip, cleared by rst_b only
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      guard_reg <= 2'b00;
      bottom_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else if (wr_stat_ok) begin
      guard_reg <= {frame_arg_reg[ST_GUARD_HI], frame_arg_reg[ST_GUARD_LO]};
      bottom_reg <= frame_arg_reg[ST_FROM_BOTTOM];
      lock_reg <= frame_arg_reg[ST_LOCK];
    end
  end

  // Published status byte plus sleep flag
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      view_reg <= VIEW_RESET;
    end else begin
      view_reg <= {mode_reg == MD_SLEEP, lock_reg, 1'b0, bottom_reg, 1'b0,
        guard_reg, latch_reg, mode_reg == MD_BUSY};
    end
  end

endmodule // sfsfe_top

/* File: sfsfe_checker.sv */
// Port checks for the serial flash front end
`timescale 1ns/10ps

module sfsfe_checker #(
  parameter int unsigned INHIBIT_CYC = 20,
  parameter int unsigned BUSY_CYC = 10
) (
  // Clock, resets
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic supply_ok,
  // Link control
  input wire logic serial_clk,
  input wire logic sel_b,
  input wire logic hold_b,
  input wire logic protect_b,
  // Data lines
  input wire logic dual_line_0_in,
  input wire logic dual_line_0_out,
  input wire logic dual_line_0_oe,
  input wire logic dual_line_1_in,
  input wire logic dual_line_1_out,
  input wire logic dual_line_1_oe
);
  // ****
  // Line drive
  // ****
  desel_float_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sel_b |-> !dual_line_0_oe && !dual_line_1_oe) else $error("Drive while deselected");
  desel_link_a: assert property (@(posedge serial_clk) disable iff (!rst_b)
    sel_b |-> !dual_line_1_oe) else $error("Drive at clock while deselected");
  out_on_fall_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(dual_line_1_out) && !sel_b && supply_ok |-> !serial_clk)
    else $error("Output moved outside clock low");
  drive_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(dual_line_1_oe) |-> !serial_clk) else $error("Drive began with clock high");
  dual_pair_a: assert property (@(posedge mclk) disable iff (!rst_b)
    dual_line_0_oe |-> dual_line_1_oe) else $error("Line 0 driven alone");
  dual_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(dual_line_0_oe) |-> !serial_clk) else $error("Line 0 drive began high");
  // Pause must float both lines; only pause, select or supply may end line 1 drive
  pause_float_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !hold_b && !serial_clk && !sel_b |-> !dual_line_0_oe && !dual_line_1_oe)
    else $error("Drive during pause");
  pause_drop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(dual_line_1_oe) |-> !hold_b || sel_b || !supply_ok) else $error("Drive dropped");
  supply_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !supply_ok |-> !dual_line_1_oe) else $error("Drive in low supply");
  // Main scenarios
  cover property (@(posedge mclk) $rose(dual_line_0_oe));
  cover property (@(posedge mclk) $rose(dual_line_1_oe));
  cover property (@(posedge mclk) !hold_b && !sel_b);
endmodule // sfsfe_checker

bind sfsfe_top sfsfe_checker #(.INHIBIT_CYC(INHIBIT_CYC), .BUSY_CYC(BUSY_CYC)) chk (
  .mclk(mclk), .rst_b(rst_b), .supply_ok(supply_ok), .serial_clk(serial_clk),
  .sel_b(sel_b), .hold_b(hold_b), .protect_b(protect_b),
  .dual_line_0_in(dual_line_0_in), .dual_line_0_out(dual_line_0_out),
  .dual_line_0_oe(dual_line_0_oe), .dual_line_1_in(dual_line_1_in),
  .dual_line_1_out(dual_line_1_out), .dual_line_1_oe(dual_line_1_oe));

/* File: sfsfe_master.sv */
// Bus master model on the flash link
`timescale 1ns/10ps

module sfsfe_master (
  // Frame pacing
  input wire logic mclk,
  // Link control
  output logic serial_clk,
  output logic sel_b,
  output logic hold_b,
  // Data lines, resolved here
  output logic dual_line_0_in,
  output logic dual_line_1_in,
  input wire logic dual_line_0_out,
  input wire logic dual_line_0_oe,
  input wire logic dual_line_1_out,
  input wire logic dual_line_1_oe
);
  localparam realtime HALF = 62.5;
  logic flt = 1'b0;
  logic d0, own0, mode3, drv, pz;
  logic [63:0] tx, rx;

  // A released line toggles so a float never reads steady
  always @(posedge mclk) flt <= ~flt;
  assign dual_line_0_in = dual_line_0_oe ? dual_line_0_out : (own0 ? d0 : flt);
  assign dual_line_1_in = dual_line_1_oe ? dual_line_1_out : flt;

  // Idle bus: deselected, clock still
  initial begin
    serial_clk = 1'b0;
    sel_b = 1'b1;
    hold_b = 1'b1;
    own0 = 1'b0;
    d0 = 1'b0;
    mode3 = 1'b0;
  end

  // ****
  // Frame
  // ****
  // Data set after falling edge, lines taken just before rising edge
  task automatic frame(input logic [7:0] op, input logic [23:0] arg, input int n,
    input int dual_at, input int hold_at);
    int i;
    tx = {op, arg, 32'h0};
    rx = '0;
    drv = 1'b0;
    pz = 1'b0;
    @(posedge mclk);
    #3.3 serial_clk = mode3;
    #HALF sel_b = 1'b0;
    for (i = 0; i < n; i++) begin
      #HALF serial_clk = 1'b0;
      own0 = (i < dual_at);
      d0 = tx[63-i];
      if (i == hold_at) begin
        // Pause taken mid low phase, clear of the shifting edge
        #(HALF / 2) hold_b = 1'b0;
        #(HALF / 2) pz = !dual_line_1_oe;
        serial_clk = 1'b1;
        #HALF serial_clk = 1'b0;
        #HALF hold_b = 1'b1;
      end
      #HALF drv = drv | dual_line_1_oe;
      if (i >= dual_at) rx = {rx[61:0], dual_line_1_in, dual_line_0_in};
      else rx = {rx[62:0], dual_line_1_in};
      serial_clk = 1'b1;
    end
    #HALF serial_clk = mode3;
    #HALF sel_b = 1'b1;
    repeat (5) @(posedge mclk);
  endtask
endmodule // sfsfe_master

/* File: tb_sfsfe_top.sv */
// Self-checking bench for the serial flash front end
`timescale 1ns/10ps

module tb_sfsfe_top;
  import sfsfe_pkg::*;
  logic mclk, rst_b, supply_ok, protect_b, serial_clk, sel_b, hold_b;
  logic dual_line_0_in, dual_line_0_out, dual_line_0_oe;
  logic dual_line_1_in, dual_line_1_out, dual_line_1_oe;
  int miscompares = 0;
  int comparisons = 0;

  // Long inhibit and busy so both show inside frames
  sfsfe_top #(.INHIBIT_CYC(300), .BUSY_CYC(800)) dut (
    .mclk(mclk), .rst_b(rst_b), .supply_ok(supply_ok), .serial_clk(serial_clk),
    .sel_b(sel_b), .hold_b(hold_b), .protect_b(protect_b),
    .dual_line_0_in(dual_line_0_in), .dual_line_0_out(dual_line_0_out),
    .dual_line_0_oe(dual_line_0_oe), .dual_line_1_in(dual_line_1_in),
    .dual_line_1_out(dual_line_1_out), .dual_line_1_oe(dual_line_1_oe));
  sfsfe_master master (
    .mclk(mclk), .serial_clk(serial_clk), .sel_b(sel_b), .hold_b(hold_b),
    .dual_line_0_in(dual_line_0_in), .dual_line_1_in(dual_line_1_in),
    .dual_line_0_out(dual_line_0_out), .dual_line_0_oe(dual_line_0_oe),
    .dual_line_1_out(dual_line_1_out), .dual_line_1_oe(dual_line_1_oe));

  // 100 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****
  // Tasks
  // ****
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] arg, input int n);
    master.frame(op, arg, n, 99, 99);
  endtask
  task automatic stat(input logic [7:0] exp);
    cmd(OP_RD_STAT, 24'h0, 16);
    check({8'h00, master.rx[7:0]}, {8'h00, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****
  // Sequence
  // ****
  // Status expectations follow every write, lock and guard step
  initial begin
    rst_b = 1'b0;
    supply_ok = 1'b1;
    protect_b = 1'b1;
    idle(5);
    rst_b <= 1'b1;
    cmd(OP_WR_EN, 24'h0, 8);
    stat(8'h00);
    idle(300);
    master.mode3 = 1'b1;
    cmd(OP_WR_EN, 24'h0, 8);
    stat(8'h02);
    cmd(OP_WR_DIS, 24'h0, 8);
    stat(8'h00);
    master.mode3 = 1'b0;
    cmd(OP_WR_EN, 24'h0, 8);
    cmd(OP_WR_STAT, 24'hFC0000, 16);
    stat(8'hAF);
    master.frame(OP_RD, 24'h0, 40, 99, 99);
    check({15'h0, master.drv}, 16'h0);
    idle(900);
    stat(8'hAC);
    @(posedge mclk) protect_b <= 1'b0;
    cmd(OP_WR_EN, 24'h0, 8);
    cmd(OP_WR_STAT, 24'h0, 16);
    stat(8'hAE);
    cmd(OP_PAGE_PROG, 24'h010000, 40);
    stat(8'hAE);
    @(posedge mclk) protect_b <= 1'b1;
    cmd(OP_WR_STAT, 24'h240000, 16);
    idle(900);
    stat(8'h24);
    cmd(OP_WR_EN, 24'h0, 8);
    cmd(OP_SECT_ERASE, 24'h010000, 32);
    stat(8'h27);
    idle(900);
    stat(8'h24);
    cmd(OP_WR_EN, 24'h0, 8);
    cmd(OP_BLK64_ERASE, 24'h0, 32);
    stat(8'h26);
    cmd(OP_WR_DIS, 24'h0, 9);
    stat(8'h26);
    cmd(OP_SLEEP, 24'h0, 8);
    cmd(OP_RD_STAT, 24'h0, 16);
    check({15'h0, master.drv}, 16'h0);
    cmd(OP_WR_DIS, 24'h0, 8);
    cmd(OP_WAKE, 24'h0, 8);
    stat(8'h26);
    master.frame(OP_DUAL_OUT, 24'h0, 48, 40, 99);
    check(master.rx[15:0], 16'hFFFF);
    master.frame(OP_DUAL_IO, 24'h0, 32, 24, 99);
    check(master.rx[15:0], 16'hFFFF);
    master.frame(OP_RD_STAT, 24'h0, 24, 99, 12);
    check({master.pz, 7'h0, master.rx[7:0]}, 16'h8026);
    @(posedge mclk) supply_ok <= 1'b0;
    idle(10);
    @(posedge mclk) supply_ok <= 1'b1;
    cmd(OP_WR_EN, 24'h0, 8);
    stat(8'h24);
    give_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    idle(40000);
    miscompares++;
    give_verdict();
  end
endmodule // tb_sfsfe_top
